// file: hw/dpcs_pkg.sv
// Shared constants of the display PLL configuration sequencer
package dpcs_pkg;
  localparam int          NUM_PLL        = 2;
  localparam int          NUM_PORT       = 2;
  localparam int          P_FLD_W        = 4;
  localparam int          K_FLD_W        = 3;
  localparam int          Q_FLD_W        = 8;
  localparam int          DCO_INT_W      = 10;
  localparam int          DCO_FRAC_W     = 15;
  localparam int          DIV_W          = 13;
  localparam int          SYM_DIV_W      = 16;
  localparam int          LOCK_CNT_W     = 16;
  // Divider field codes
  localparam logic [3:0]  P_CODE_2       = 4'h1;
  localparam logic [3:0]  P_CODE_3       = 4'h2;
  localparam logic [3:0]  P_CODE_5       = 4'h4;
  localparam logic [3:0]  P_CODE_7       = 4'h8;
  localparam logic [2:0]  K_CODE_1       = 3'h1;
  localparam logic [2:0]  K_CODE_2       = 3'h2;
  localparam logic [2:0]  K_CODE_3       = 3'h4;
  localparam logic [7:0]  Q_ONE          = 8'h01;
  localparam logic [15:0] SYM_FACTOR     = 16'h0005;
  // Spread spectrum encoding
  localparam logic        SSC_ON         = 1'b1;
  localparam logic        SSC_OFF        = 1'b0;
  // Port clock source select
  localparam logic [1:0]  SEL_FIRST_PLL  = 2'h0;
  localparam logic [1:0]  SEL_SECOND_PLL = 2'h1;
  // Reference frequency strap field
  localparam logic [1:0]  REF_19P2       = 2'h0;
  localparam logic [1:0]  REF_24         = 2'h1;
  localparam logic [1:0]  REF_38P4       = 2'h2;
  localparam logic [1:0]  REF_RST        = 2'h0;
  localparam logic [1:0]  STRAP_WAIT     = 2'h2;
  // Timing
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          LOCK_TIME_NS   = 50000;
  localparam int          UNLOCK_TIME_NS = 1000;
  localparam int          LOCK_MAX_CYC   = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int          UNLOCK_MAX_CYC = UNLOCK_TIME_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_POWERED = 2'b01,
    ST_LOCKING = 2'b10,
    ST_LOCKED  = 2'b11
  } dpcs_state_t;
endpackage

// file: hw/dpcs_port_gate.sv
// Per-port clock source select and glitch-safe gate
`timescale 1ns/10ps
module dpcs_port_gate (
  input  wire logic       clk_sys_i,    // System clock
  input  wire logic       rst_b_i,      // Async reset, active low
  input  wire logic [1:0] src_sel_i,    // Clock source select
  input  wire logic       clk_off_i,    // Port clock off, 1 = stopped
  input  wire logic [1:0] pll_ready_i,  // Per PLL powered and locked
  output logic      [1:0] src_q_o,      // Registered source select
  output logic            gate_en_o     // Port clock enable
);
  logic       sel_valid;
  logic       src_ready;
  logic       gate_d;
  logic       gate_q;
  logic [1:0] src_q;

  assign sel_valid = (src_sel_i == dpcs_pkg::SEL_FIRST_PLL) ||
                     (src_sel_i == dpcs_pkg::SEL_SECOND_PLL);
  assign src_ready = (src_sel_i == dpcs_pkg::SEL_FIRST_PLL)  ? pll_ready_i[0] :
                     (src_sel_i == dpcs_pkg::SEL_SECOND_PLL) ? pll_ready_i[1] : 1'b0;
  // Gate stays shut unless source is valid, powered and locked
  assign gate_d    = ~clk_off_i & sel_valid & src_ready;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate_q <= 1'b0;
      src_q  <= dpcs_pkg::SEL_FIRST_PLL;
    end else begin
      gate_q <= gate_d;
      src_q  <= src_sel_i;
    end
  end

  assign gate_en_o = gate_q;
  assign src_q_o   = src_q;

  a_gate_needs_lock: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    gate_q |-> $past(src_ready) && !$past(clk_off_i))
    else $error("port clock open without locked source");
  a_gate_off_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    clk_off_i |=> !gate_q)
    else $error("port clock running while off bit set");
  a_gate_src_lost: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (gate_q && !src_ready) |=> !gate_q)
    else $error("port clock not gated after source lost lock");
  c_gate_open: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) $rose(gate_q));
endmodule // dpcs_port_gate

// file: hw/dpcs_pll_chan.sv
// One display PLL: power, configuration shadow, legality and lock model
`timescale 1ns/10ps
module dpcs_pll_chan #(
  parameter int LOCK_CYC = dpcs_pkg::LOCK_MAX_CYC
) (
  input  wire logic        clk_sys_i,    // System clock
  input  wire logic        rst_b_i,      // Async reset, active low
  input  wire logic        power_en_i,   // PLL power enable
  input  wire logic        pll_en_i,     // PLL enable
  input  wire logic        ssc_en_i,     // Spread spectrum enable
  input  wire logic [9:0]  dco_int_i,    // Oscillator ratio integer
  input  wire logic [14:0] dco_frac_i,   // Oscillator ratio fraction
  input  wire logic [3:0]  p_code_i,     // P divider code
  input  wire logic [2:0]  k_code_i,     // K divider code
  input  wire logic [7:0]  q_ratio_i,    // Q divider ratio
  input  wire logic        q_mode_i,     // Q divider mode
  input  wire logic        err_clr_i,    // Clear sticky change error
  output logic             power_on_o,   // Power state enabled
  output logic             lock_o,       // Lock status
  output logic             cfg_err_o,    // Divider settings illegal
  output logic             chg_err_o,    // Config changed while enabled
  output logic             ssc_on_o,     // Spread spectrum running
  output logic [12:0]      div_total_o,  // P*Q*K of running config
  output logic [15:0]      sym_div_o,    // 5*P*Q*K, oscillator to symbol
  output logic [24:0]      dco_ratio_o   // Running oscillator ratio
);
  dpcs_pkg::dpcs_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [3:0]  p_q;
  logic [2:0]  k_q;
  logic [7:0]  q_ratio_q;
  logic        q_mode_q, ssc_q;
  logic [24:0] dco_q;
  logic        shadow_load, legal, p_ok, k_ok, cfg_diff, lock_hit;
  logic [2:0]  p_val;
  logic [1:0]  k_val;
  logic [7:0]  q_eff, q_eff_in;
  logic        power_q, lock_q, cfg_err_q, chg_err_q, ssc_on_q;
  logic [12:0] div_q;
  logic [15:0] sym_q;

  // Shadow tracks the inputs only in the OFF and POWERED states, even with pll_en_i set
  assign shadow_load = (state_q == dpcs_pkg::ST_OFF) || (state_q == dpcs_pkg::ST_POWERED);
  assign cfg_diff    = ({dco_int_i, dco_frac_i} != dco_q) || (p_code_i != p_q) ||
                       (k_code_i != k_q) || (q_ratio_i != q_ratio_q) ||
                       (q_mode_i != q_mode_q) || (ssc_en_i != ssc_q);
  assign p_ok  = (p_code_i == dpcs_pkg::P_CODE_2) || (p_code_i == dpcs_pkg::P_CODE_3) ||
                 (p_code_i == dpcs_pkg::P_CODE_5) || (p_code_i == dpcs_pkg::P_CODE_7);
  assign k_ok  = (k_code_i == dpcs_pkg::K_CODE_1) || (k_code_i == dpcs_pkg::K_CODE_2) ||
                 (k_code_i == dpcs_pkg::K_CODE_3);
  assign q_eff_in = q_mode_i ? q_ratio_i : dpcs_pkg::Q_ONE;
  assign legal = p_ok && k_ok && (q_eff_in != 8'h00) &&
                 ((k_code_i == dpcs_pkg::K_CODE_2) || (q_eff_in == dpcs_pkg::Q_ONE));
  assign p_val = (p_q == dpcs_pkg::P_CODE_2) ? 3'h2 :
                 (p_q == dpcs_pkg::P_CODE_3) ? 3'h3 :
                 (p_q == dpcs_pkg::P_CODE_5) ? 3'h5 : 3'h7;
  assign k_val = (k_q == dpcs_pkg::K_CODE_2) ? 2'h2 :
                 (k_q == dpcs_pkg::K_CODE_3) ? 2'h3 : 2'h1;
  assign q_eff = q_mode_q ? q_ratio_q : dpcs_pkg::Q_ONE;
  assign lock_hit = (cnt_q == 16'(LOCK_CYC - 2));

  always_comb begin
    state_d = state_q;
    case (state_q)
      dpcs_pkg::ST_OFF: begin
        if (power_en_i) state_d = dpcs_pkg::ST_POWERED;
      end
      dpcs_pkg::ST_POWERED: begin
        if (!power_en_i) state_d = dpcs_pkg::ST_OFF;
        else if (pll_en_i && legal) state_d = dpcs_pkg::ST_LOCKING;
      end
      dpcs_pkg::ST_LOCKING: begin
        if (!power_en_i) state_d = dpcs_pkg::ST_OFF;
        else if (!pll_en_i) state_d = dpcs_pkg::ST_POWERED;
        else if (lock_hit) state_d = dpcs_pkg::ST_LOCKED;
      end
      dpcs_pkg::ST_LOCKED: begin
        if (!power_en_i) state_d = dpcs_pkg::ST_OFF;
        else if (!pll_en_i) state_d = dpcs_pkg::ST_POWERED;
      end
      default: state_d = dpcs_pkg::ST_OFF;
    endcase
  end

  assign cnt_d = (state_q == dpcs_pkg::ST_LOCKING) ? cnt_q + 16'h0001 : 16'h0000;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= dpcs_pkg::ST_OFF;
      cnt_q   <= 16'h0000;
      power_q <= 1'b0;
      lock_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      power_q <= (state_d != dpcs_pkg::ST_OFF);
      lock_q  <= (state_d == dpcs_pkg::ST_LOCKED);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dco_q     <= 25'h0000000;
      p_q       <= dpcs_pkg::P_CODE_2;
      k_q       <= dpcs_pkg::K_CODE_1;
      q_ratio_q <= 8'h00;
      q_mode_q  <= 1'b0;
      ssc_q     <= dpcs_pkg::SSC_OFF;
    end else if (shadow_load) begin
      dco_q     <= {dco_int_i, dco_frac_i};
      p_q       <= p_code_i;
      k_q       <= k_code_i;
      q_ratio_q <= q_ratio_i;
      q_mode_q  <= q_mode_i;
      ssc_q     <= ssc_en_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_err_q <= 1'b0;
      chg_err_q <= 1'b0;
      ssc_on_q  <= 1'b0;
      div_q     <= 13'h0000;
      sym_q     <= 16'h0000;
    end else begin
      cfg_err_q <= ~legal;
      // Set wins over clear
      chg_err_q <= (~shadow_load & cfg_diff) | (chg_err_q & ~err_clr_i);
      ssc_on_q  <= (ssc_q == dpcs_pkg::SSC_ON) && (state_q == dpcs_pkg::ST_LOCKED);
      div_q     <= 13'(16'(p_val) * 16'(q_eff) * 16'(k_val));
      sym_q     <= 16'(div_q) * dpcs_pkg::SYM_FACTOR;
    end
  end

  assign power_on_o  = power_q;
  assign lock_o      = lock_q;
  assign cfg_err_o   = cfg_err_q;
  assign chg_err_o   = chg_err_q;
  assign ssc_on_o    = ssc_on_q;
  assign div_total_o = div_q;
  assign sym_div_o   = sym_q;
  assign dco_ratio_o = dco_q;

  a_lock_needs_power: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    lock_q |-> power_q && $past(pll_en_i))
    else $error("lock reported without power and enable");
  a_lock_delay_exact: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $rose(lock_q) |-> $past(cnt_q) == 16'(LOCK_CYC - 2))
    else $error("lock rose at wrong count");
  a_unlock_fast: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !pll_en_i |=> !lock_q)
    else $error("lock held after disable");
  a_power_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    power_en_i |=> power_q)
    else $error("power state did not follow enable");
  a_cfg_held_locked: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    lock_q && $past(lock_q) |-> $stable(dco_q) && $stable(p_q) && $stable(q_ratio_q))
    else $error("running config changed while locked");
  a_illegal_no_lock: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_q == dpcs_pkg::ST_POWERED && !legal) |=> state_q != dpcs_pkg::ST_LOCKING)
    else $error("illegal dividers started locking");
  a_q_mode_off: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !q_mode_q |=> div_q == ({10'h000, $past(p_val)} * {11'h000, $past(k_val)}))
    else $error("Q divider applied with mode off");
  c_pll_locked: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) $rose(lock_q));
  c_chg_err: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) $rose(chg_err_q));
endmodule // dpcs_pll_chan

// file: hw/dpcs_top.sv
// Display PLL config sequencer top: two PLLs, reference strap, two port gates
`timescale 1ns/10ps
module dpcs_top #(
  parameter int LOCK_CYC = dpcs_pkg::LOCK_MAX_CYC
) (
  input  wire logic             clk_sys_i,     // System clock, 100 MHz
  input  wire logic             rst_b_i,       // Async reset, active low
  input  wire logic [1:0]       ref_strap_i,   // Reference frequency strap pins
  input  wire logic [1:0]       power_en_i,    // Per PLL power enable
  input  wire logic [1:0]       pll_en_i,      // Per PLL enable
  input  wire logic [1:0]       ssc_en_i,      // Per PLL spread spectrum enable
  input  wire logic [1:0][9:0]  dco_int_i,     // Per PLL oscillator ratio integer
  input  wire logic [1:0][14:0] dco_frac_i,    // Per PLL oscillator ratio fraction
  input  wire logic [1:0][3:0]  p_code_i,      // Per PLL P divider code
  input  wire logic [1:0][2:0]  k_code_i,      // Per PLL K divider code
  input  wire logic [1:0][7:0]  q_ratio_i,     // Per PLL Q ratio
  input  wire logic [1:0]       q_mode_i,      // Per PLL Q mode
  input  wire logic [1:0]       err_clr_i,     // Per PLL clear change error
  input  wire logic [1:0][1:0]  port_sel_i,    // Per port clock source select
  input  wire logic [1:0]       port_off_i,    // Per port clock off
  output logic      [1:0]       ref_freq_o,    // Reference frequency field
  output logic                  ref_halved_o,  // Reference halved internally
  output logic      [1:0]       power_on_o,    // Per PLL power state
  output logic      [1:0]       lock_o,        // Per PLL lock
  output logic      [1:0]       cfg_err_o,     // Per PLL illegal dividers
  output logic      [1:0]       chg_err_o,     // Per PLL sticky change error
  output logic      [1:0]       ssc_on_o,      // Per PLL spread running
  output logic      [1:0][12:0] div_total_o,   // Per PLL P*Q*K
  output logic      [1:0][15:0] sym_div_o,     // Per PLL 5*P*Q*K
  output logic      [1:0][24:0] dco_ratio_o,   // Per PLL running ratio
  output logic      [1:0][1:0]  port_src_o,    // Per port registered source
  output logic      [1:0]       port_clk_en_o  // Per port clock enable
);
  logic [1:0] strap_s1_q, strap_s2_q;
  logic [1:0] strap_cnt_q;
  logic [1:0] ref_q;
  logic       halved_q;
  logic       strap_take;
  logic [1:0] pll_power, pll_lock, pll_ready;

  // Strap passes a two-stage synchroniser and is captured once after release
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_s1_q <= dpcs_pkg::REF_RST;
      strap_s2_q <= dpcs_pkg::REF_RST;
    end else begin
      strap_s1_q <= ref_strap_i;
      strap_s2_q <= strap_s1_q;
    end
  end

  assign strap_take = (strap_cnt_q == dpcs_pkg::STRAP_WAIT);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_cnt_q <= 2'h0;
      ref_q       <= dpcs_pkg::REF_RST;
      halved_q    <= 1'b0;
    end else begin
      if (strap_cnt_q != 2'h3) strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_take) begin
        ref_q    <= strap_s2_q;
        halved_q <= (strap_s2_q == dpcs_pkg::REF_38P4);
      end
    end
  end

  assign ref_freq_o   = ref_q;
  assign ref_halved_o = halved_q;

  genvar gi;
  generate
    for (gi = 0; gi < dpcs_pkg::NUM_PLL; gi++) begin : g_pll
      dpcs_pll_chan #(
        .LOCK_CYC (LOCK_CYC)
      ) u_chan (
        .clk_sys_i   (clk_sys_i),
        .rst_b_i     (rst_b_i),
        .power_en_i  (power_en_i[gi]),
        .pll_en_i    (pll_en_i[gi]),
        .ssc_en_i    (ssc_en_i[gi]),
        .dco_int_i   (dco_int_i[gi]),
        .dco_frac_i  (dco_frac_i[gi]),
        .p_code_i    (p_code_i[gi]),
        .k_code_i    (k_code_i[gi]),
        .q_ratio_i   (q_ratio_i[gi]),
        .q_mode_i    (q_mode_i[gi]),
        .err_clr_i   (err_clr_i[gi]),
        .power_on_o  (pll_power[gi]),
        .lock_o      (pll_lock[gi]),
        .cfg_err_o   (cfg_err_o[gi]),
        .chg_err_o   (chg_err_o[gi]),
        .ssc_on_o    (ssc_on_o[gi]),
        .div_total_o (div_total_o[gi]),
        .sym_div_o   (sym_div_o[gi]),
        .dco_ratio_o (dco_ratio_o[gi])
      );
      assign pll_ready[gi] = pll_power[gi] & pll_lock[gi];
    end
    for (gi = 0; gi < dpcs_pkg::NUM_PORT; gi++) begin : g_port
      dpcs_port_gate u_gate (
        .clk_sys_i   (clk_sys_i),
        .rst_b_i     (rst_b_i),
        .src_sel_i   (port_sel_i[gi]),
        .clk_off_i   (port_off_i[gi]),
        .pll_ready_i (pll_ready),
        .src_q_o     (port_src_o[gi]),
        .gate_en_o   (port_clk_en_o[gi])
      );
    end
  endgenerate

  assign power_on_o = pll_power;
  assign lock_o     = pll_lock;

  a_ref_halved: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    strap_cnt_q == 2'h3 |-> halved_q == (ref_q == dpcs_pkg::REF_38P4))
    else $error("halved flag disagrees with reference field");
  a_ref_stable: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    strap_cnt_q == 2'h3 && $past(strap_cnt_q) == 2'h3 |-> $stable(ref_q))
    else $error("reference field changed after capture");
  c_ref_38p4: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) $rose(halved_q));
endmodule // dpcs_top

// file: tb/dpcs_sw_model.sv
// Software-side model that powers, enables and waits on one PLL
`timescale 1ns/10ps
module dpcs_sw_model (
  input  wire logic clk_sys_i,   // System clock
  input  wire logic power_on_i,  // Power state from device
  input  wire logic lock_i,      // Lock status from device
  output logic      power_en_o,  // Power enable to device
  output logic      pll_en_o,    // PLL enable to device
  output logic      ssc_en_o     // Spread spectrum select
);
  initial begin
    power_en_o = 1'b0;
    pll_en_o = 1'b0;
    ssc_en_o = dpcs_pkg::SSC_OFF;
  end
  // Drive power (0) or enable (1), count edges until status follows, bounded at 64
  task automatic step(input int which, input logic val, output int n);
    n = 0;
    @(posedge clk_sys_i);
    #1;
    if (which == 0) power_en_o = val;
    else pll_en_o = val;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while ((((which == 0) ? power_on_i : lock_i) !== val) && (n < 64));
  endtask
  // Spread spectrum is chosen after power-up, before the frequency fields
  task automatic set_ssc(input logic tmds);
    @(posedge clk_sys_i);
    #1;
    ssc_en_o = tmds ? dpcs_pkg::SSC_OFF : dpcs_pkg::SSC_ON;
  endtask
endmodule // dpcs_sw_model

// file: tb/dpcs_top_tb_top.sv
// Self-checking bench of the display PLL config sequencer
`timescale 1ns/10ps
module dpcs_top_tb_top;
  localparam int LCYC = 8;
  logic             clk_sys_i;
  logic             rst_b_i;
  logic [1:0]       strap, qm, eclr, poff, rfq, pon, lck, cerr, cherr, sscon, gate;
  wire  logic [1:0] pe, le, se;
  logic [1:0][9:0]  dint;
  logic [1:0][14:0] dfrac;
  logic [1:0][3:0]  pc;
  logic [1:0][2:0]  kc;
  logic [1:0][7:0]  qr;
  logic [1:0][1:0]  psel, psrc;
  logic             halved;
  logic [1:0][12:0] dtot;
  logic [1:0][15:0] sdiv;
  logic [1:0][24:0] drat;
  int               failures, check_count, cyc;

  dpcs_top #(.LOCK_CYC(LCYC)) i_dpcs_top (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ref_strap_i(strap), .power_en_i(pe),
    .pll_en_i(le), .ssc_en_i(se), .dco_int_i(dint), .dco_frac_i(dfrac), .p_code_i(pc),
    .k_code_i(kc), .q_ratio_i(qr), .q_mode_i(qm), .err_clr_i(eclr), .port_sel_i(psel),
    .port_off_i(poff), .ref_freq_o(rfq), .ref_halved_o(halved), .power_on_o(pon),
    .lock_o(lck), .cfg_err_o(cerr), .chg_err_o(cherr), .ssc_on_o(sscon), .div_total_o(dtot),
    .sym_div_o(sdiv), .dco_ratio_o(drat), .port_src_o(psrc), .port_clk_en_o(gate));
  dpcs_sw_model i_dpcs_sw_model0 (.clk_sys_i(clk_sys_i), .power_on_i(pon[0]), .lock_i(lck[0]),
    .power_en_o(pe[0]), .pll_en_o(le[0]), .ssc_en_o(se[0]));
  dpcs_sw_model i_dpcs_sw_model1 (.clk_sys_i(clk_sys_i), .power_on_i(pon[1]), .lock_i(lck[1]),
    .power_en_o(pe[1]), .pll_en_o(le[1]), .ssc_en_o(se[1]));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if ((failures == 0) && (check_count > 0)) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic cmp_val(input logic [24:0] got, input logic [24:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      failures++;
      $display("BAD t=%0t count got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask
  function automatic int exp_div(input logic [3:0] p, input logic [2:0] k, input logic [7:0] q,
                                 input logic m);
    int pv;
    int kv;
    pv = (p == dpcs_pkg::P_CODE_2) ? 2 : (p == dpcs_pkg::P_CODE_3) ? 3 :
         (p == dpcs_pkg::P_CODE_5) ? 5 : 7;
    kv = (k == dpcs_pkg::K_CODE_1) ? 1 : (k == dpcs_pkg::K_CODE_2) ? 2 : 3;
    return pv * kv * (m ? int'(q) : 1);
  endfunction
  task automatic set_cfg(input int p, input logic [3:0] pv, input logic [2:0] kv,
                         input logic [7:0] qv, input logic mv, input logic [9:0] iv);
    pc[p] = pv;
    kc[p] = kv;
    qr[p] = qv;
    qm[p] = mv;
    dint[p] = iv;
    dfrac[p] = (p == 0) ? 15'h7000 : 15'h592c;
  endtask
  task automatic sw_step(input int p, input int which, input logic val, output int n);
    if (p == 0) i_dpcs_sw_model0.step(which, val, n);
    else i_dpcs_sw_model1.step(which, val, n);
  endtask

  initial begin
    int n, p, q, e;
    logic [3:0] lp;
    logic [2:0] lk;
    logic [7:0] lq;
    logic       lm;
    rst_b_i = 1'b0;
    {strap, qm, eclr, psel, dint, dfrac, pc, kc, qr} = '0;
    poff = 2'h3;
    void'($urandom(91));
    for (int c = 0; c < 4; c++) begin
      strap = 2'(c);
      rst_b_i = 1'b0;
      tick(8);
      cmp_val(25'({pon, lck, gate}), 25'h0);
      rst_b_i = 1'b1;
      tick(4);
      cmp_val(25'(rfq), 25'(c));
      cmp_val(25'(halved), 25'(strap == dpcs_pkg::REF_38P4));
    end
    $display("Test reference strap done");
    for (int i = 0; i < 8; i++) begin
      p = i % 2;
      q = (i / 2) % 2;
      sw_step(p, 0, 1'b1, n);
      cmp_cnt(n, 1);
      if (p == 0) i_dpcs_sw_model0.set_ssc(1'b0);
      else i_dpcs_sw_model1.set_ssc(1'b1);
      lp = 4'(1 << ($urandom % 4));
      lk = 3'(1 << ($urandom % 3));
      lm = 1'($urandom % 2);
      lq = (lk == dpcs_pkg::K_CODE_2) ? 8'($urandom_range(1, 255)) : (lm ? 8'h01 : 8'($urandom));
      // Corner cases: in-band oscillator nearest centre, divider 16 split as P2 Q4 K2
      if (i == 0) set_cfg(p, dpcs_pkg::P_CODE_3, dpcs_pkg::K_CODE_2, 8'h00, 1'b0, 10'h1a5);
      else if (i == 1) set_cfg(p, dpcs_pkg::P_CODE_2, dpcs_pkg::K_CODE_2, 8'h04, 1'b1, 10'h179);
      else set_cfg(p, lp, lk, lq, lm, 10'($urandom));
      tick(3);
      e = exp_div(pc[p], kc[p], qr[p], qm[p]);
      cmp_val(25'(cerr[p]), 25'h0);
      cmp_val(25'(dtot[p]), 25'(e));
      cmp_val(25'(sdiv[p]), 25'(5 * e));
      cmp_val(drat[p], {dint[p], dfrac[p]});
      sw_step(p, 1, 1'b1, n);
      cmp_cnt(n, LCYC);
      // Spread-spectrum status is registered one edge after lock
      tick(1);
      cmp_val(25'(sscon[p]), 25'(p == 0));
      dint[p] = ~dint[p];
      tick(2);
      cmp_val(25'(cherr[p]), 25'h1);
      cmp_val(drat[p], {~dint[p], dfrac[p]});
      dint[p] = ~dint[p];
      eclr[p] = 1'b1;
      tick(1);
      eclr[p] = 1'b0;
      tick(1);
      cmp_val(25'(cherr[p]), 25'h0);
      psel[q] = 2'h2 + 2'(p);
      poff[q] = 1'b0;
      tick(2);
      cmp_val(25'(gate[q]), 25'h0);
      psel[q] = 2'(p);
      tick(1);
      cmp_val(25'(gate[q]), 25'h1);
      cmp_val(25'(psrc[q]), 25'(p));
      psel[1 - q] = 2'(1 - p);
      poff[1 - q] = 1'b0;
      tick(2);
      cmp_val(25'(gate[1 - q]), 25'h0);
      poff[1 - q] = 1'b1;
      sw_step(p, 1, 1'b0, n);
      cmp_cnt(n, 1);
      tick(1);
      cmp_val(25'(gate[q]), 25'h0);
      poff[q] = 1'b1;
      sw_step(p, 0, 1'b0, n);
      cmp_cnt(n, 1);
      $display("Test bring-up %0d done", i);
    end
    for (int j = 0; j < 4; j++) begin
      sw_step(0, 0, 1'b1, n);
      lp = (j == 0) ? 4'h3 : dpcs_pkg::P_CODE_3;
      lk = (j == 1) ? 3'h3 : ((j == 3) ? dpcs_pkg::K_CODE_2 : dpcs_pkg::K_CODE_1);
      lq = (j == 2) ? 8'h02 : 8'h00;
      set_cfg(0, lp, lk, lq, 1'(j >= 2), 10'h1a5);
      tick(2);
      cmp_val(25'(cerr[0]), 25'h1);
      sw_step(0, 1, 1'b1, n);
      cmp_cnt(n, 64);
      cmp_val(25'(pon[0]), 25'h1);
      sw_step(0, 1, 1'b0, n);
      sw_step(0, 0, 1'b0, n);
      $display("Test illegal divider %0d done", j);
    end
    stop_test();
  end
endmodule // dpcs_top_tb_top
